/* hdl/sfpp_pkg.sv */
// Constants, types and states shared by the page program sequencer
`default_nettype none
package sfpp_pkg;
   localparam int ADDR_W     = 24;
   localparam int ADDR_BYTES = ADDR_W / 8;
   localparam int PAGE_BYTES = 256;

   localparam logic [7:0] OPC_PAGE_PROG   = 8'h02;
   localparam logic [7:0] OPC_DUAL_PROG   = 8'hA2;
   localparam logic [7:0] OPC_DUAL_X_PROG = 8'hD2;
   localparam logic [7:0] OPC_QUAD_PROG   = 8'h32;
   localparam logic [7:0] OPC_QUAD_X_PROG = 8'h38;
   localparam logic [7:0] OPC_CLR_FLAGS   = 8'h50;

   localparam int         FSR_PROT_BIT      = 1;
   localparam int         FSR_PROG_SUSP_BIT = 2;
   localparam int         FSR_PROG_ERR_BIT  = 4;
   localparam int         FSR_READY_BIT     = 7;
   localparam logic [7:0] FSR_RESET         = 8'h80;

   localparam int CLK_PERIOD_NS          = 20;
   localparam int PAGE_WRITE_DURATION_NS = 500_000;
   localparam int PAGE_WRITE_CYC         = (PAGE_WRITE_DURATION_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int PROG_TIMEOUT_NS        = 5_000_000;
   localparam int PROG_TIMEOUT_CYC       = PROG_TIMEOUT_NS / CLK_PERIOD_NS;

   typedef enum logic [1:0] {
      SFPP_MODE_EXT  = 2'h0,
      SFPP_MODE_DUAL = 2'h1,
      SFPP_MODE_QUAD = 2'h2
   } sfpp_mode_e;

   typedef enum logic [2:0] {
      SFPP_LANE_1 = 3'b001,
      SFPP_LANE_2 = 3'b010,
      SFPP_LANE_4 = 3'b100
   } sfpp_lanes_e;

   typedef enum logic [3:0] {
      SFPP_BP_OPC  = 4'b0001,
      SFPP_BP_ADDR = 4'b0010,
      SFPP_BP_DATA = 4'b0100,
      SFPP_BP_SKIP = 4'b1000
   } sfpp_phase_e;

   typedef enum logic [5:0] {
      SFPP_EN_IDLE  = 6'b00_0001,
      SFPP_EN_SCAN  = 6'b00_0010,
      SFPP_EN_FETCH = 6'b00_0100,
      SFPP_EN_MERGE = 6'b00_1000,
      SFPP_EN_STORE = 6'b01_0000,
      SFPP_EN_HOLD  = 6'b10_0000
   } sfpp_engine_e;

   typedef struct packed {
      logic       wip;
      logic       wel;
      logic [7:0] flags;
   } sfpp_status_s;

   typedef struct packed {
      logic              rd_en;
      logic              wr_en;
      logic [ADDR_W-1:0] addr;
      logic [7:0]        data;
   } sfpp_arr_req_s;
endpackage
`default_nettype wire

/* hdl/sfpp_lane_rx.sv */
// Serial lane deserialiser: gathers one, two or four bits per clock rise into bytes
`default_nettype none
module sfpp_lane_rx (
   // Clock and reset
   input  wire logic                  clock,
   input  wire logic                  sys_rst,
   // Serial pins
   input  wire logic                  sclk,
   input  wire logic                  cs_n,
   input  wire logic [3:0]            dq,
   input  wire sfpp_pkg::sfpp_lanes_e lanes,
   // Assembled bytes
   output logic                       byte_stb,
   output logic [7:0]                 byte_val,
   output logic                       aligned
);
   logic       sclk_q;
   logic [7:0] shreg;
   logic [3:0] cnt;
   logic       next_sclk_q;
   logic [7:0] next_shreg;
   logic [3:0] next_cnt;
   logic       next_byte_stb;
   logic [7:0] next_byte_val;

   assign aligned = (cnt == 4'h0);

   always_comb begin
      next_sclk_q   = sclk;
      next_shreg    = shreg;
      next_cnt      = cnt;
      next_byte_stb = 1'b0;
      next_byte_val = byte_val;
      if (cs_n) begin
         next_cnt = 4'h0;
      end else if (sclk && !sclk_q) begin
         case (lanes)
            sfpp_pkg::SFPP_LANE_2: begin
               next_shreg = {shreg[5:0], dq[1:0]};
               next_cnt   = cnt + 4'h2;
            end
            sfpp_pkg::SFPP_LANE_4: begin
               next_shreg = {shreg[3:0], dq[3:0]};
               next_cnt   = cnt + 4'h4;
            end
            default: begin
               next_shreg = {shreg[6:0], dq[0]};
               next_cnt   = cnt + 4'h1;
            end
         endcase
         if (next_cnt == 4'h8) begin
            next_cnt      = 4'h0;
            next_byte_stb = 1'b1;
            next_byte_val = next_shreg;
         end
      end
   end

   always_ff @(posedge clock) begin
      if (sys_rst) begin
         sclk_q   <= 1'b0;
         shreg    <= 8'h00;
         cnt      <= 4'h0;
         byte_stb <= 1'b0;
         byte_val <= 8'h00;
      end else begin
         sclk_q   <= next_sclk_q;
         shreg    <= next_shreg;
         cnt      <= next_cnt;
         byte_stb <= next_byte_stb;
         byte_val <= next_byte_val;
      end
   end
endmodule
`default_nettype wire

/* hdl/sfpp_page_program.sv */
// Page program sequencer: command decode, page buffer and self-timed array programming
`default_nettype none
module sfpp_page_program #(
   parameter int          PAGE_BYTES       = sfpp_pkg::PAGE_BYTES,
   parameter int unsigned PAGE_WRITE_CYC   = sfpp_pkg::PAGE_WRITE_CYC,
   parameter int unsigned PROG_TIMEOUT_CYC = sfpp_pkg::PROG_TIMEOUT_CYC
) (
   // Clock and reset
   input  wire logic                         clock,
   input  wire logic                         sys_rst,
   // Serial bus from the host
   input  wire logic                         spi_sclk,
   input  wire logic                         spi_cs_n,
   input  wire logic [3:0]                   spi_dq,
   input  wire sfpp_pkg::sfpp_mode_e         link_mode,
   // Control hooks
   input  wire logic                         wel_set,
   input  wire logic                         suspend_req,
   input  wire logic                         resume_req,
   // Sector protection lookup
   output logic [sfpp_pkg::ADDR_W-1:0]       prot_addr,
   input  wire logic                         addr_protected,
   // Flash array port
   output sfpp_pkg::sfpp_arr_req_s           arr_req,
   input  wire logic [7:0]                   arr_rd_data,
   input  wire logic                         arr_wr_ack,
   // Status for polling
   output sfpp_pkg::sfpp_status_s            status,
   output logic                              suspended
);
   localparam int OFS_W = $clog2(PAGE_BYTES);

   sfpp_pkg::sfpp_lanes_e   lanes;
   logic                    byte_stb;
   logic [7:0]              byte_val;
   logic                    aligned;

   sfpp_pkg::sfpp_phase_e   phase;
   sfpp_pkg::sfpp_phase_e   next_phase;
   logic [7:0]              opcode;
   logic [7:0]              next_opcode;
   logic [1:0]              addr_cnt;
   logic [1:0]              next_addr_cnt;
   logic [OFS_W-1:0]        wofs;
   logic [OFS_W-1:0]        next_wofs;
   logic                    has_data;
   logic                    next_has_data;
   logic                    cs_q;
   logic [PAGE_BYTES-1:0]   valid;
   logic [PAGE_BYTES-1:0]   next_valid;
   logic [7:0]              page_buf [PAGE_BYTES];
   logic                    buf_we;
   logic [sfpp_pkg::ADDR_W-1:0] next_prot_addr;

   sfpp_pkg::sfpp_engine_e  eng;
   sfpp_pkg::sfpp_engine_e  next_eng;
   logic [OFS_W-1:0]        idx;
   logic [OFS_W-1:0]        next_idx;
   logic [31:0]             timer;
   logic [31:0]             next_timer;
   sfpp_pkg::sfpp_arr_req_s next_arr_req;
   sfpp_pkg::sfpp_status_s  next_status;
   logic                    next_suspended;

   logic                    is_prog;
   logic                    cs_rise;
   logic                    go;
   logic [7:0]              flag_set;
   logic [7:0]              flag_clr;
   logic                    wel_clr;

   sfpp_lane_rx u_rx (
      .clock    (clock),
      .sys_rst  (sys_rst),
      .sclk     (spi_sclk),
      .cs_n     (spi_cs_n),
      .dq       (spi_dq),
      .lanes    (lanes),
      .byte_stb (byte_stb),
      .byte_val (byte_val),
      .aligned  (aligned)
   );

   // Opcode family decode
   assign is_prog = (opcode == sfpp_pkg::OPC_PAGE_PROG) ||
                    (opcode == sfpp_pkg::OPC_DUAL_PROG) || (opcode == sfpp_pkg::OPC_DUAL_X_PROG) ||
                    (opcode == sfpp_pkg::OPC_QUAD_PROG) || (opcode == sfpp_pkg::OPC_QUAD_X_PROG);
   assign cs_rise = spi_cs_n && !cs_q;
   assign buf_we  = byte_stb && (phase == sfpp_pkg::SFPP_BP_DATA);

   // Line count per phase: extended mode widens only the phases the opcode names
   always_comb begin
      lanes = sfpp_pkg::SFPP_LANE_1;
      if (link_mode == sfpp_pkg::SFPP_MODE_DUAL) begin
         lanes = sfpp_pkg::SFPP_LANE_2;
      end else if (link_mode == sfpp_pkg::SFPP_MODE_QUAD) begin
         lanes = sfpp_pkg::SFPP_LANE_4;
      end else if (phase == sfpp_pkg::SFPP_BP_ADDR) begin
         if (opcode == sfpp_pkg::OPC_DUAL_X_PROG) lanes = sfpp_pkg::SFPP_LANE_2;
         if (opcode == sfpp_pkg::OPC_QUAD_X_PROG) lanes = sfpp_pkg::SFPP_LANE_4;
      end else if (phase == sfpp_pkg::SFPP_BP_DATA) begin
         if (opcode == sfpp_pkg::OPC_DUAL_PROG || opcode == sfpp_pkg::OPC_DUAL_X_PROG) begin
            lanes = sfpp_pkg::SFPP_LANE_2;
         end
         if (opcode == sfpp_pkg::OPC_QUAD_PROG || opcode == sfpp_pkg::OPC_QUAD_X_PROG) begin
            lanes = sfpp_pkg::SFPP_LANE_4;
         end
      end
   end

   // Command capture: opcode, address and data into the page buffer
   always_comb begin
      next_phase     = phase;
      next_opcode    = opcode;
      next_addr_cnt  = addr_cnt;
      next_wofs      = wofs;
      next_has_data  = has_data;
      next_valid     = valid;
      next_prot_addr = prot_addr;
      flag_clr       = 8'h00;
      if (spi_cs_n) begin
         next_phase = sfpp_pkg::SFPP_BP_OPC;
      end else if (byte_stb) begin
         case (phase)
            sfpp_pkg::SFPP_BP_OPC: begin
               // Page still in use by the engine is left alone while busy
               if (!status.wip) begin
                  next_opcode   = byte_val;
                  next_addr_cnt = 2'h0;
                  next_has_data = 1'b0;
                  next_valid    = '0;
               end
               next_phase = sfpp_pkg::SFPP_BP_SKIP;
               if (status.wip) begin
                  next_phase = sfpp_pkg::SFPP_BP_SKIP;
               end else if (byte_val == sfpp_pkg::OPC_CLR_FLAGS) begin
                  flag_clr[sfpp_pkg::FSR_PROT_BIT]     = 1'b1;
                  flag_clr[sfpp_pkg::FSR_PROG_ERR_BIT] = 1'b1;
               end else if (byte_val == sfpp_pkg::OPC_PAGE_PROG || byte_val == sfpp_pkg::OPC_DUAL_PROG ||
                            byte_val == sfpp_pkg::OPC_DUAL_X_PROG || byte_val == sfpp_pkg::OPC_QUAD_PROG ||
                            byte_val == sfpp_pkg::OPC_QUAD_X_PROG) begin
                  next_phase = sfpp_pkg::SFPP_BP_ADDR;
               end
            end
            sfpp_pkg::SFPP_BP_ADDR: begin
               next_prot_addr = {prot_addr[sfpp_pkg::ADDR_W-9:0], byte_val};
               next_addr_cnt  = addr_cnt + 2'h1;
               if (addr_cnt == 2'(sfpp_pkg::ADDR_BYTES - 1)) begin
                  next_wofs  = next_prot_addr[OFS_W-1:0];
                  next_phase = sfpp_pkg::SFPP_BP_DATA;
               end
            end
            sfpp_pkg::SFPP_BP_DATA: begin
               next_valid[wofs] = 1'b1;
               next_wofs        = wofs + OFS_W'(1);
               next_has_data    = 1'b1;
            end
            sfpp_pkg::SFPP_BP_SKIP: begin
               next_phase = sfpp_pkg::SFPP_BP_SKIP;
            end
            default: begin
               next_phase = sfpp_pkg::SFPP_BP_SKIP;
            end
         endcase
      end
   end

   // Start only on a complete, byte-aligned program frame with the latch set
   assign go = cs_rise && (phase == sfpp_pkg::SFPP_BP_DATA) && has_data && aligned && is_prog
               && status.wel && !status.wip;

   always_ff @(posedge clock) begin
      if (buf_we) begin
         page_buf[wofs] <= byte_val;
      end
   end

   // Programming engine and status
   always_comb begin
      next_eng       = eng;
      next_idx       = idx;
      next_timer     = timer;
      next_arr_req   = arr_req;
      next_suspended = suspended;
      flag_set       = 8'h00;
      wel_clr        = 1'b0;
      next_status    = status;
      if (go) begin
         if (addr_protected) begin
            flag_set[sfpp_pkg::FSR_PROT_BIT]     = 1'b1;
            flag_set[sfpp_pkg::FSR_PROG_ERR_BIT] = 1'b1;
         end else begin
            next_status.wip                       = 1'b1;
            next_status.flags[sfpp_pkg::FSR_READY_BIT] = 1'b0;
            next_timer                            = 32'h0000_0000;
            next_idx                              = '0;
            next_eng                              = sfpp_pkg::SFPP_EN_SCAN;
         end
      end
      if (eng != sfpp_pkg::SFPP_EN_IDLE) begin
         if (!suspended) next_timer = timer + 32'h0000_0001;
         if (suspend_req && !suspended) begin
            next_suspended                              = 1'b1;
            next_status.flags[sfpp_pkg::FSR_PROG_SUSP_BIT] = 1'b1;
            next_status.flags[sfpp_pkg::FSR_READY_BIT]     = 1'b1;
         end else if (resume_req && suspended) begin
            next_suspended                              = 1'b0;
            next_status.flags[sfpp_pkg::FSR_PROG_SUSP_BIT] = 1'b0;
            next_status.flags[sfpp_pkg::FSR_READY_BIT]     = 1'b0;
         end
      end
      case (eng)
         sfpp_pkg::SFPP_EN_IDLE: begin
            next_arr_req.rd_en = 1'b0;
            next_arr_req.wr_en = 1'b0;
         end
         sfpp_pkg::SFPP_EN_SCAN: begin
            if (!suspended) begin
               if (valid[idx]) begin
                  next_arr_req.rd_en = 1'b1;
                  next_arr_req.addr  = {prot_addr[sfpp_pkg::ADDR_W-1:OFS_W], idx};
                  next_eng           = sfpp_pkg::SFPP_EN_FETCH;
               end else if (idx == OFS_W'(PAGE_BYTES - 1)) begin
                  next_eng = sfpp_pkg::SFPP_EN_HOLD;
               end else begin
                  next_idx = idx + OFS_W'(1);
               end
            end
         end
         sfpp_pkg::SFPP_EN_FETCH: begin
            next_arr_req.rd_en = 1'b0;
            next_eng           = sfpp_pkg::SFPP_EN_MERGE;
         end
         sfpp_pkg::SFPP_EN_MERGE: begin
            next_arr_req.wr_en = 1'b1;
            next_arr_req.data  = arr_rd_data & page_buf[idx];
            next_eng           = sfpp_pkg::SFPP_EN_STORE;
         end
         sfpp_pkg::SFPP_EN_STORE: begin
            if (arr_wr_ack) begin
               next_arr_req.wr_en = 1'b0;
               if (idx == OFS_W'(PAGE_BYTES - 1)) begin
                  next_eng = sfpp_pkg::SFPP_EN_HOLD;
               end else begin
                  next_idx = idx + OFS_W'(1);
                  next_eng = sfpp_pkg::SFPP_EN_SCAN;
               end
            end
         end
         sfpp_pkg::SFPP_EN_HOLD: begin
            if (!suspended && timer >= PAGE_WRITE_CYC) begin
               next_eng                                   = sfpp_pkg::SFPP_EN_IDLE;
               next_status.wip                            = 1'b0;
               next_status.flags[sfpp_pkg::FSR_READY_BIT] = 1'b1;
               wel_clr                                    = 1'b1;
            end
         end
         default: begin
            next_eng = sfpp_pkg::SFPP_EN_IDLE;
         end
      endcase
      if (eng != sfpp_pkg::SFPP_EN_IDLE && timer >= PROG_TIMEOUT_CYC) begin
         next_eng                                   = sfpp_pkg::SFPP_EN_IDLE;
         next_arr_req.rd_en                         = 1'b0;
         next_arr_req.wr_en                         = 1'b0;
         next_suspended                             = 1'b0;
         next_status.wip                            = 1'b0;
         next_status.flags[sfpp_pkg::FSR_READY_BIT] = 1'b1;
         next_status.flags[sfpp_pkg::FSR_PROG_SUSP_BIT] = 1'b0;
         flag_set[sfpp_pkg::FSR_PROG_ERR_BIT]       = 1'b1;
         wel_clr                                    = 1'b1;
      end
      // Hardware set wins over a simultaneous clear
      next_status.flags = (next_status.flags & ~flag_clr) | flag_set;
      next_status.wel   = wel_set || (status.wel && !wel_clr);
   end

   always_ff @(posedge clock) begin
      if (sys_rst) begin
         phase     <= sfpp_pkg::SFPP_BP_OPC;
         opcode    <= 8'h00;
         addr_cnt  <= 2'h0;
         wofs      <= '0;
         has_data  <= 1'b0;
         cs_q      <= 1'b1;
         valid     <= '0;
         prot_addr <= '0;
         eng       <= sfpp_pkg::SFPP_EN_IDLE;
         idx       <= '0;
         timer     <= 32'h0000_0000;
         arr_req   <= '0;
         suspended <= 1'b0;
         status    <= '{wip: 1'b0, wel: 1'b0, flags: sfpp_pkg::FSR_RESET};
      end else begin
         phase     <= next_phase;
         opcode    <= next_opcode;
         addr_cnt  <= next_addr_cnt;
         wofs      <= next_wofs;
         has_data  <= next_has_data;
         cs_q      <= spi_cs_n;
         valid     <= next_valid;
         prot_addr <= next_prot_addr;
         eng       <= next_eng;
         idx       <= next_idx;
         timer     <= next_timer;
         arr_req   <= next_arr_req;
         suspended <= next_suspended;
         status    <= next_status;
      end
   end
endmodule
`default_nettype wire

/* testbench/sfpp_page_program_sva.sv */
// Assertions on the page program sequencer ports
`default_nettype none
module sfpp_page_program_sva #(
   parameter int unsigned PAGE_WRITE_CYC   = 200,
   parameter int unsigned PROG_TIMEOUT_CYC = 4000
) (
   // Clock and reset
   input wire logic                    clock,
   input wire logic                    sys_rst,
   // Hooks
   input wire logic                    suspend_req,
   // Array and status
   input wire sfpp_pkg::sfpp_arr_req_s arr_req,
   input wire logic                    arr_wr_ack,
   input wire sfpp_pkg::sfpp_status_s  status,
   input wire logic                    suspended
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [31:0] busy_cnt;
   logic [31:0] next_busy_cnt;
   default clocking cb @(posedge clock); endclocking
   default disable iff (sys_rst);
   // Busy cycles outside suspension
   always_comb begin
      next_busy_cnt = status.wip ? busy_cnt + {31'h0, !suspended} : 32'h0000_0000;
   end
   always_ff @(posedge clock) begin
      busy_cnt <= sys_rst ? 32'h0000_0000 : next_busy_cnt;
   end
   a_wel_gate: assert property ($rose(status.wip) |-> $past(status.wel))
      else $error("program started without write enable");
   a_busy_ready: assert property (status.wip && !suspended |-> !status.flags[7])
      else $error("ready flag high while programming");
   a_end_wel: assert property ($fell(status.wip) |-> !status.wel)
      else $error("write enable kept after program end");
   a_end_ready: assert property ($fell(status.wip) |-> status.flags[7] && !suspended)
      else $error("ready flag low after program end");
   a_prot_flags: assert property ($rose(status.flags[1]) |-> status.flags[4] && status.wel && !status.wip)
      else $error("protection refusal reported wrongly");
   a_fail_flag: assert property ($rose(status.flags[4]) && !status.flags[1]
      |-> !status.wel && !status.wip && busy_cnt + 2 >= PROG_TIMEOUT_CYC)
      else $error("program failure flag without timeout");
   a_prog_len: assert property ($fell(status.wip)
      |-> busy_cnt + 2 >= PAGE_WRITE_CYC && busy_cnt <= PROG_TIMEOUT_CYC + 2)
      else $error("program duration out of range");
   a_wr_hold: assert property (arr_req.wr_en && !arr_wr_ack
      |=> !status.wip || (arr_req.wr_en && $stable(arr_req.data) && $stable(arr_req.addr)))
      else $error("array write dropped before acknowledge");
   a_susp_flags: assert property ($rose(suspended) |-> $past(suspend_req) && status.flags[2] && status.flags[7])
      else $error("suspend flags wrong");
   a_susp_pause: assert property (suspended && $past(suspended) |-> !arr_req.rd_en && status.wip)
      else $error("array read while suspended");
   c_done: cover property ($fell(status.wip));
   c_prot: cover property ($rose(status.flags[1]));
   c_susp: cover property ($rose(suspended));
endmodule
bind sfpp_page_program sfpp_page_program_sva #(.PAGE_WRITE_CYC(PAGE_WRITE_CYC), .PROG_TIMEOUT_CYC(PROG_TIMEOUT_CYC))
   u_sva (.clock(clock), .sys_rst(sys_rst), .suspend_req(suspend_req), .arr_req(arr_req),
          .arr_wr_ack(arr_wr_ack), .status(status), .suspended(suspended));
`default_nettype wire

/* testbench/sfpp_host_model.sv */
// Host controller model: write enable pulse and serial program frames
`default_nettype none
module sfpp_host_model (
   // Clock
   input  wire logic  clock,
   // Serial bus and write enable
   output logic       spi_sclk,
   output logic       spi_cs_n,
   output logic [3:0] spi_dq,
   output logic       wel_set
);
   timeunit 1ns;
   timeprecision 1ns;
   initial begin
      spi_sclk = 1'b0;
      spi_cs_n = 1'b1;
      spi_dq = 4'h0;
      wel_set = 1'b0;
   end
   task automatic wren();
      @(negedge clock) wel_set = 1'b1;
      @(negedge clock) wel_set = 1'b0;
   endtask
   // Shifts one byte MSB first, k bits per clock rise
   task automatic put(input logic [7:0] b, input int k);
      for (int i = 8; i > 0; i -= k) begin
         @(negedge clock) spi_sclk = 1'b0;
         spi_dq = 4'(b >> (i - k)) & 4'((1 << k) - 1);
         repeat (2) @(negedge clock);
         spi_sclk = 1'b1;
         repeat (2) @(negedge clock);
      end
   endtask
   task automatic frame(input logic [7:0] opc, input logic [23:0] adr, input int nb, input logic [7:0] first,
                        input int lo, input int la, input int ld, input int extra);
      @(negedge clock) spi_cs_n = 1'b0;
      put(opc, lo);
      if (la > 0) for (int i = 2; i >= 0; i--) put(adr[8*i +: 8], la);
      for (int i = 0; i < nb; i++) put(8'(first + i + (i >> 8)), ld);
      repeat (extra) put(8'h01, 8);
      @(negedge clock) spi_sclk = 1'b0;
      repeat (2) @(negedge clock);
      spi_cs_n = 1'b1;
      spi_dq = ~spi_dq;
   endtask
endmodule
`default_nettype wire

/* testbench/test_serial_flash_page_program.sv */
// Self-checking bench for the page program sequencer
`default_nettype none
module test_serial_flash_page_program;
   timeunit 1ns;
   timeprecision 1ns;
   logic                    clock, sys_rst, spi_sclk, spi_cs_n, wel_set, suspend_req, resume_req;
   logic                    addr_protected, arr_wr_ack, suspended, stall, acked;
   logic [3:0]              spi_dq;
   logic [23:0]             prot_addr;
   logic [7:0]              arr_rd_data;
   logic [7:0]              mem [256];
   logic [7:0]              exp_m [256];
   sfpp_pkg::sfpp_mode_e    link_mode;
   sfpp_pkg::sfpp_arr_req_s arr_req;
   sfpp_pkg::sfpp_status_s  status;
   int                      n_fail, total_checks;

   sfpp_page_program #(.PAGE_BYTES(256), .PAGE_WRITE_CYC(200), .PROG_TIMEOUT_CYC(4000)) DUT (
      .clock(clock), .sys_rst(sys_rst), .spi_sclk(spi_sclk), .spi_cs_n(spi_cs_n), .spi_dq(spi_dq),
      .link_mode(link_mode), .wel_set(wel_set), .suspend_req(suspend_req), .resume_req(resume_req),
      .prot_addr(prot_addr), .addr_protected(addr_protected), .arr_req(arr_req), .arr_rd_data(arr_rd_data),
      .arr_wr_ack(arr_wr_ack), .status(status), .suspended(suspended));
   sfpp_host_model HOST (.clock(clock), .spi_sclk(spi_sclk), .spi_cs_n(spi_cs_n), .spi_dq(spi_dq),
      .wel_set(wel_set));

   // Sector 7Fxxxx is protected; array acknowledges writes promptly unless stalled
   assign addr_protected = (prot_addr[23:16] == 8'h7F);
   always @(negedge clock) begin
      if (arr_req.rd_en) arr_rd_data <= mem[arr_req.addr[7:0]];
      arr_wr_ack <= arr_req.wr_en && !acked && !stall;
      if (arr_req.wr_en && !acked && !stall) mem[arr_req.addr[7:0]] <= arr_req.data;
      acked <= arr_req.wr_en && (acked || !stall);
   end

   initial begin
      clock = 1'b0;
      forever #10 clock = ~clock;
   end

   task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] want);
      total_checks++;
      if (seen !== want) begin
         n_fail++;
         $display("[ERR] %s expected %h seen %h", what, want, seen);
      end
   endtask
   task automatic settle();
      int n;
      for (n = 0; n < 6000 && status.wip !== 1'b0; n++) @(negedge clock);
      chk("program end", n < 6000, 1);
   endtask
   task automatic prog(input logic [7:0] opc, input sfpp_pkg::sfpp_mode_e m, input int lo, input int la,
                       input int ld, input logic [7:0] off, input int nb);
      link_mode = m;
      for (int i = 0; i < 256; i++) mem[i] = 8'(i * 37);
      exp_m = mem;
      for (int i = 0; i < nb; i++) exp_m[8'(off + i)] = mem[8'(off + i)] & 8'(8'hA5 + i + (i >> 8));
      HOST.wren();
      HOST.frame(opc, {16'h0123, off}, nb, 8'hA5, lo, la, ld, 0);
      repeat (3) @(negedge clock);
      chk("wip busy", status.wip, 1);
      settle();
      chk("status end", 32'(status), 32'h0000_0080);
      for (int i = 0; i < 256; i++) chk("page byte", mem[i], exp_m[i]);
   endtask
   task automatic t_reset();
      chk("status reset", 32'(status), 32'h0000_0080);
      chk("array idle", {arr_req.rd_en, arr_req.wr_en, suspended}, 0);
   endtask
   task automatic t_refused();
      HOST.frame(8'h02, 24'h01_2300, 1, 8'h00, 1, 1, 1, 0);
      repeat (5) @(negedge clock);
      chk("no write enable", 32'(status), 32'h0000_0080);
      HOST.wren();
      HOST.frame(8'h02, 24'h01_2300, 1, 8'h00, 1, 1, 1, 3);
      repeat (5) @(negedge clock);
      chk("odd bits", 32'(status), 32'h0000_0180);
   endtask
   task automatic t_protect();
      HOST.frame(8'h02, 24'h7F_0010, 2, 8'h00, 1, 1, 1, 0);
      repeat (5) @(negedge clock);
      chk("protected", 32'(status), 32'h0000_0192);
      HOST.frame(8'h50, 24'h00_0000, 0, 8'h00, 1, 0, 1, 0);
      repeat (5) @(negedge clock);
      chk("flags cleared", status.flags, 8'h80);
   endtask
   task automatic t_modes();
      prog(8'h02, sfpp_pkg::SFPP_MODE_EXT, 1, 1, 1, 8'hFE, 4);
      prog(8'hA2, sfpp_pkg::SFPP_MODE_EXT, 1, 1, 2, 8'h10, 3);
      prog(8'hD2, sfpp_pkg::SFPP_MODE_EXT, 1, 2, 2, 8'h20, 3);
      prog(8'h32, sfpp_pkg::SFPP_MODE_EXT, 1, 1, 4, 8'h30, 3);
      prog(8'h38, sfpp_pkg::SFPP_MODE_EXT, 1, 4, 4, 8'hFF, 3);
      prog(8'h02, sfpp_pkg::SFPP_MODE_DUAL, 2, 2, 2, 8'h50, 2);
      prog(8'h02, sfpp_pkg::SFPP_MODE_QUAD, 4, 4, 4, 8'h60, 2);
   endtask
   task automatic t_overflow();
      prog(8'h02, sfpp_pkg::SFPP_MODE_EXT, 1, 1, 1, 8'h00, 258);
   endtask
   task automatic t_suspend();
      fork
         prog(8'h02, sfpp_pkg::SFPP_MODE_EXT, 1, 1, 1, 8'h40, 8);
         begin
            for (int n = 0; n < 2000 && status.wip !== 1'b1; n++) @(negedge clock);
            @(negedge clock) suspend_req = 1'b1;
            @(negedge clock) suspend_req = 1'b0;
            repeat (2) @(negedge clock);
            chk("suspended", {suspended, status.flags[2], status.flags[7]}, 3'h7);
            HOST.frame(8'h02, 24'h01_2340, 1, 8'h00, 1, 1, 1, 0);
            repeat (100) @(negedge clock);
            chk("held busy", status.wip, 1);
            resume_req = 1'b1;
            @(negedge clock) resume_req = 1'b0;
            repeat (2) @(negedge clock);
            chk("resumed", {suspended, status.flags[2], status.flags[7]}, 3'h0);
         end
      join
   endtask
   task automatic t_timeout();
      stall = 1'b1;
      HOST.wren();
      HOST.frame(8'h02, 24'h01_2300, 1, 8'h00, 1, 1, 1, 0);
      repeat (3) @(negedge clock);
      settle();
      chk("timeout", 32'(status), 32'h0000_0090);
      stall = 1'b0;
   endtask
   task automatic wrap_up();
      if (n_fail == 0 && total_checks > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask

   initial begin
      #2_000_000;
      n_fail++;
      wrap_up();
   end
   initial begin
      {sys_rst, suspend_req, resume_req, stall, acked, arr_wr_ack} = 6'h20;
      arr_rd_data = 8'h00;
      link_mode = sfpp_pkg::SFPP_MODE_EXT;
      n_fail = 0;
      total_checks = 0;
      repeat (5) @(negedge clock);
      sys_rst = 1'b0;
      t_reset();
      t_refused();
      t_protect();
      t_modes();
      t_overflow();
      t_suspend();
      t_timeout();
      wrap_up();
   end
endmodule
`default_nettype wire
